// file: inc/fcd_pkg.sv
package fcd_pkg;
   localparam int NCH = 4; // channel count
   localparam int AW = 24; // data memory address width
   localparam int DW = 16; // element width
   localparam int CW = 14; // block length field width
   localparam int SELW = 8; // request select code width
   localparam int NREQ = 256; // request lines, one per code
   localparam int BUF_DEPTH = 2; // entries in the transfer buffer

   // addressing modes
   localparam logic [1:0] AMODE_INC = 2'h0;
   localparam logic [1:0] AMODE_FIX = 2'h1;
   localparam logic [1:0] AMODE_PIA = 2'h2;
   // operating mode field positions
   localparam int MODE_ONESHOT_BIT = 0;
   localparam int MODE_PINGPONG_BIT = 1;

   localparam logic [AW-1:0] STEP_BYTE = 24'h000001; // address step, byte elements
   localparam logic [AW-1:0] STEP_WORD = 24'h000002; // address step, word elements
   localparam logic [AW-1:0] ADDR_RST = 24'h000000; // offset reset value
   localparam logic [15:0] PADR_NONE = 16'h0000; // no peripheral address given

   // request select codes
   localparam logic [SELW-1:0] SRC_EXT_INT_ZERO = 8'h00;
   localparam logic [SELW-1:0] SRC_CAPTURE_TWO = 8'h05;
   localparam logic [SELW-1:0] SRC_COMPARE_TWO = 8'h06;
   localparam logic [SELW-1:0] SRC_SECOND_TIMER = 8'h07;
   localparam logic [SELW-1:0] SRC_THIRD_TIMER = 8'h08;
   localparam logic [SELW-1:0] SRC_UART_ONE_RX = 8'h0B;
   localparam logic [SELW-1:0] SRC_CONVERTER_ONE = 8'h0D;
   localparam logic [SELW-1:0] SRC_CAN_ONE_RX = 8'h22;
   localparam logic [SELW-1:0] SRC_CODEC = 8'h3C;
   // peripheral data register addresses
   localparam logic [15:0] CAPTURE_BUFFER_TWO = 16'h014C;
   localparam logic [15:0] COMPARE_VALUE_TWO = 16'h0910;
   localparam logic [15:0] SECONDARY_COMPARE_VALUE_TWO = 16'h090E;
   localparam logic [15:0] UART_ONE_RECEIVE_REGISTER = 16'h0226;
   localparam logic [15:0] CONVERTER_ONE_RESULT_ZERO = 16'h0300;
   localparam logic [15:0] CAN_ONE_RECEIVE_DATA = 16'h0440;
   localparam logic [15:0] CODEC_RECEIVE_BUFFER_ZERO = 16'h0290;
   localparam logic [15:0] CODEC_TRANSMIT_BUFFER_ZERO = 16'h0298;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_READ = 2'b10} fcd_state_t;

   // one element in flight from the read phase to the write phase
   typedef struct packed {
      logic [DW-1:0] data;
      logic [AW-1:0] addr;
      logic is_byte;
      logic [1:0] chan;
      logic irq;
   } fcd_entry_t;

   // default peripheral address for a request code and direction
   function automatic logic [15:0] fcd_default_padr(input logic [SELW-1:0] sel, input logic to_periph);
      logic [15:0] a;
      a = PADR_NONE;
      unique case (sel)
         SRC_CAPTURE_TWO: a = to_periph ? PADR_NONE : CAPTURE_BUFFER_TWO;
         SRC_COMPARE_TWO: a = to_periph ? COMPARE_VALUE_TWO : PADR_NONE;
         SRC_UART_ONE_RX: a = to_periph ? PADR_NONE : UART_ONE_RECEIVE_REGISTER;
         SRC_CONVERTER_ONE: a = to_periph ? PADR_NONE : CONVERTER_ONE_RESULT_ZERO;
         SRC_CAN_ONE_RX: a = to_periph ? PADR_NONE : CAN_ONE_RECEIVE_DATA;
         SRC_CODEC: a = to_periph ? CODEC_TRANSMIT_BUFFER_ZERO : CODEC_RECEIVE_BUFFER_ZERO;
         default: a = PADR_NONE;
      endcase
      return a;
   endfunction : fcd_default_padr
endpackage : fcd_pkg

// file: inc/fcd_buf_if.sv
interface fcd_buf_if;
   import fcd_pkg::*;
   logic in_valid; // engine offers an entry
   logic in_ready; // buffer has room
   fcd_entry_t in_data;
   logic out_valid; // buffer holds an entry
   logic out_ready; // engine takes the head entry
   fcd_entry_t out_data;
   modport engine(output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
   modport store(input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface : fcd_buf_if

// file: hw/fcd_xfer_buf.sv
module fcd_xfer_buf (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   fcd_buf_if.store bus
);
   import fcd_pkg::*;

   // whole buffer state
   typedef struct packed {
      fcd_entry_t [BUF_DEPTH-1:0] mem; // entry storage
      logic wp; // write index
      logic rp; // read index
      logic [1:0] cnt; // occupancy
   } fcd_buf_t;

   fcd_buf_t s_r;
   fcd_buf_t s_nxt;
   logic push;
   logic pop;

   // honest flags straight from the occupancy count
   assign bus.in_ready = (s_r.cnt != 2'(BUF_DEPTH));
   assign bus.out_valid = (s_r.cnt != 2'h0);
   assign bus.out_data = s_r.mem[s_r.rp];
   assign push = bus.in_valid & bus.in_ready;
   assign pop = bus.out_valid & bus.out_ready;

   // next state: store on push, advance on pop
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = bus.in_data;
         s_nxt.wp = ~s_r.wp;
      end
      if (pop) begin
         s_nxt.rp = ~s_r.rp;
      end
      s_nxt.cnt = s_r.cnt + 2'(push) - 2'(pop);
   end

   // state register
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   no_overfill_a: assert property (s_r.cnt <= 2'(BUF_DEPTH)) else $error("buffer count above depth");
endmodule : fcd_xfer_buf

// file: hw/fcd_dma.sv
// Functional notes
// - four channels, each with own configuration
// - each channel moves data one way only
// - coinciding requests: one granted, others stay pending
// - block end raises channel interrupt pulse
// - interrupt at half block or full block
// - half select one: midpoint; zero: end
// - byte or word elements per channel
// - direction one: RAM to peripheral, zero reverse
// - RAM address post-increments or stays fixed
// - peripheral supplied address used in indirect mode
// - start by software force or request line
// - force cleared on completion or disable
// - one-shot stops after block, in ping-pong after the B block; continuous restarts
// - ping-pong swaps start address per block
// - eight-bit code selects request source
// - timer and external interrupt codes usable
// - memory accesses wait for arbiter grant
// - addresses span whole data memory
// - capture two code and buffer address
// - compare two code and value addresses
// - uart one receive code and address
// - converter one code and result address
// - can one receive code and address
// - codec code and buffer addresses
// - disabled channel performs no transfers
module fcd_dma (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [fcd_pkg::NCH-1:0] chan_enable_i,
   input wire logic [fcd_pkg::NCH-1:0] byte_size_i,
   input wire logic [fcd_pkg::NCH-1:0] dir_to_periph_i,
   input wire logic [fcd_pkg::NCH-1:0] half_irq_i,
   input wire logic [fcd_pkg::NCH-1:0][1:0] amode_i,
   input wire logic [fcd_pkg::NCH-1:0][1:0] mode_i,
   input wire logic [fcd_pkg::NCH-1:0][fcd_pkg::SELW-1:0] request_source_select_i,
   input wire logic [fcd_pkg::NCH-1:0] force_set_i,
   input wire logic [fcd_pkg::NCH-1:0][fcd_pkg::AW-1:0] start_a_i,
   input wire logic [fcd_pkg::NCH-1:0][fcd_pkg::AW-1:0] start_b_i,
   input wire logic [fcd_pkg::NCH-1:0][15:0] channel_peripheral_address_i,
   input wire logic [fcd_pkg::NCH-1:0][fcd_pkg::CW-1:0] count_i,
   input wire logic [fcd_pkg::NREQ-1:0] req_lines_i,
   input wire logic [fcd_pkg::AW-1:0] pia_addr_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_byte_o,
   output logic [fcd_pkg::AW-1:0] mem_addr_o,
   output logic [fcd_pkg::DW-1:0] mem_wdata_o,
   input wire logic mem_gnt_i,
   input wire logic [fcd_pkg::DW-1:0] mem_rdata_i,
   output logic [fcd_pkg::NCH-1:0] block_irq_o,
   output logic [fcd_pkg::NCH-1:0] force_o,
   output logic [fcd_pkg::NCH-1:0] pending_o,
   output logic [fcd_pkg::NCH-1:0] ping_o,
   output logic [fcd_pkg::NCH-1:0] stopped_o,
   output logic busy_o
);
   import fcd_pkg::*;

   // whole engine state
   typedef struct packed {
      fcd_state_t st; // read phase sequencer
      logic [1:0] cur; // channel in service
      logic [NCH-1:0] pend; // request seen, not yet served
      logic [NCH-1:0] force_b; // software force, hardware clears
      logic [NCH-1:0] stopped; // one-shot finished
      logic [NCH-1:0] ping; // buffer B selected
      logic [NCH-1:0] irq; // interrupt pulses
      logic [NCH-1:0][AW-1:0] off; // RAM offset within block
      logic [NCH-1:0][CW:0] moved; // elements moved in block
   } fcd_core_t;

   fcd_core_t s_r;
   fcd_core_t s_nxt;
   logic rst_sync_r; // first reset stage, read only by the second
   logic rst_n; // released reset used everywhere
   logic [NCH-1:0] req_ev; // selected request line per channel
   logic [NCH-1:0] want; // channels eligible for grant
   logic [1:0] low; // lowest eligible channel
   logic rd_go; // read phase owns the bus
   logic rd_done; // read taken by arbiter
   logic wr_done; // write taken by arbiter
   logic c_dir;
   logic c_pp;
   logic c_os;
   logic c_last;
   logic c_half;
   logic [1:0] c_amode;
   logic [AW-1:0] c_step;
   logic [AW-1:0] c_ram;
   logic [AW-1:0] c_padr;
   logic [CW:0] c_len;
   logic [CW:0] c_mv;
   logic [15:0] padr16;

   fcd_buf_if ibuf ();

   // two-entry buffer between read and write phases; a stalled write lets it fill
   fcd_xfer_buf u_buf (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n),
      .bus    (ibuf.store)
   );

   // reset release through two stages, assertion stays asynchronous
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync_r <= 1'b1;
         rst_n <= rst_sync_r;
      end
   end

   // request routing and eligibility per channel
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         req_ev[c] = req_lines_i[request_source_select_i[c]];
         want[c] = (s_r.pend[c] | s_r.force_b[c]) & chan_enable_i[c] & ~s_r.stopped[c];
      end
      low = 2'h0;
      // scan downwards so the lowest number is left standing
      for (int c = NCH - 1; c >= 0; c--) begin
         if (want[c]) begin
            low = 2'(c);
         end
      end
   end

   // element addressing for the channel in service
   always_comb begin
      c_dir = dir_to_periph_i[s_r.cur];
      c_pp = mode_i[s_r.cur][MODE_PINGPONG_BIT];
      c_os = mode_i[s_r.cur][MODE_ONESHOT_BIT];
      c_amode = amode_i[s_r.cur];
      c_step = byte_size_i[s_r.cur] ? STEP_BYTE : STEP_WORD;
      // peripheral address of zero falls back to the source's known register
      padr16 = channel_peripheral_address_i[s_r.cur];
      if (padr16 == PADR_NONE) begin
         padr16 = fcd_default_padr(request_source_select_i[s_r.cur], c_dir);
      end
      c_padr = AW'(padr16);
      if (c_amode == AMODE_PIA) begin
         c_ram = pia_addr_i;
      end else begin
         // full-width adder, any data memory location reachable
         c_ram = (s_r.ping[s_r.cur] ? start_b_i[s_r.cur] : start_a_i[s_r.cur]) + s_r.off[s_r.cur];
      end
      c_len = (CW + 1)'(count_i[s_r.cur]) + 15'h0001;
      c_mv = s_r.moved[s_r.cur] + 15'h0001;
      c_last = (c_mv == c_len);
      // odd lengths round the midpoint down; length one gives no half interrupt
      c_half = (c_mv == (c_len >> 1));
   end

   // bus sharing: reads first while the buffer has room, writes drain otherwise
   // a channel disabled while waiting must not touch memory, so its read is gated here
   assign rd_go = (s_r.st == ST_READ) & chan_enable_i[s_r.cur] & ibuf.in_ready;
   assign rd_done = rd_go & mem_gnt_i;
   assign ibuf.out_ready = mem_gnt_i & ~rd_go;
   assign wr_done = ibuf.out_valid & ibuf.out_ready;
   assign ibuf.in_valid = rd_done;
   assign ibuf.in_data.data = mem_rdata_i;
   assign ibuf.in_data.addr = c_dir ? c_padr : c_ram;
   assign ibuf.in_data.is_byte = byte_size_i[s_r.cur];
   assign ibuf.in_data.chan = s_r.cur;
   assign ibuf.in_data.irq = half_irq_i[s_r.cur] ? c_half : c_last;

   // memory port toward the arbiter
   assign mem_req_o = rd_go | ibuf.out_valid;
   assign mem_we_o = ~rd_go & ibuf.out_valid;
   assign mem_byte_o = rd_go ? byte_size_i[s_r.cur] : ibuf.out_data.is_byte;
   assign mem_addr_o = rd_go ? (c_dir ? c_ram : c_padr) : ibuf.out_data.addr;
   assign mem_wdata_o = ibuf.out_data.data;

   assign block_irq_o = s_r.irq;
   assign force_o = s_r.force_b;
   assign pending_o = s_r.pend;
   assign ping_o = s_r.ping;
   assign stopped_o = s_r.stopped;
   assign busy_o = (s_r.st == ST_READ) | ibuf.out_valid;

   // next state of the engine
   always_comb begin
      s_nxt = s_r;
      s_nxt.irq = '0;
      unique case (s_r.st)
         ST_IDLE: begin
            if (|want) begin
               s_nxt.cur = low;
               s_nxt.st = ST_READ;
            end
         end
         ST_READ: begin
            // disabled while waiting for the bus: give it up, nothing moved
            if (!chan_enable_i[s_r.cur]) begin
               s_nxt.st = ST_IDLE;
            end
            if (rd_done) begin
               s_nxt.st = ST_IDLE;
               s_nxt.pend[s_r.cur] = 1'b0;
               s_nxt.force_b[s_r.cur] = 1'b0;
               if (c_amode == AMODE_INC) begin
                  s_nxt.off[s_r.cur] = s_r.off[s_r.cur] + c_step;
               end
               s_nxt.moved[s_r.cur] = c_mv;
               if (c_last) begin
                  // block complete: rewind, swap buffers, maybe stop
                  s_nxt.off[s_r.cur] = ADDR_RST;
                  s_nxt.moved[s_r.cur] = '0;
                  if (c_pp) begin
                     s_nxt.ping[s_r.cur] = ~s_r.ping[s_r.cur];
                  end
                  // one-shot ping-pong ends after the B block
                  if (c_os && (!c_pp || s_r.ping[s_r.cur])) begin
                     s_nxt.stopped[s_r.cur] = 1'b1;
                  end
               end
            end
         end
      endcase
      // interrupt only once the flagged element has reached its destination
      if (wr_done && ibuf.out_data.irq) begin
         s_nxt.irq[ibuf.out_data.chan] = 1'b1;
      end
      for (int c = 0; c < NCH; c++) begin
         // new events applied after the grant clear, so set wins
         if (req_ev[c] && !s_r.stopped[c]) begin
            s_nxt.pend[c] = 1'b1;
         end
         if (force_set_i[c]) begin
            s_nxt.force_b[c] = 1'b1;
         end
         // a disabled channel forgets everything and restarts clean
         if (!chan_enable_i[c]) begin
            s_nxt.pend[c] = 1'b0;
            s_nxt.force_b[c] = 1'b0;
            s_nxt.stopped[c] = 1'b0;
            s_nxt.ping[c] = 1'b0;
            s_nxt.off[c] = ADDR_RST;
            s_nxt.moved[c] = '0;
         end
      end
   end

   // state register
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: ST_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   sequence s_grant;
      (s_r.st == ST_IDLE) && (|want);
   endsequence
   sequence s_flag_write;
      wr_done && ibuf.out_data.irq;
   endsequence
   sequence s_block_end;
      rd_done && c_last;
   endsequence

   grant_lowest_a: assert property (s_grant |=> (s_r.cur == $past(low)) && (s_r.st == ST_READ))
      else $error("grant not given to lowest eligible channel");
   loser_pending_a: assert property (rd_done |=> ((($past(s_r.pend) & ~(4'h1 << $past(s_r.cur)))
      & $past(chan_enable_i) & chan_enable_i & ~s_r.pend) == 4'h0))
      else $error("losing channel dropped its pending request");
   disable_clear_a: assert property (1'b1 |=> ((s_r.force_b | s_r.pend) & ~$past(chan_enable_i)) == 4'h0)
      else $error("disabled channel kept force or pending");
   // index by the current cur: one cycle back it may still name the previous channel
   enabled_only_a: assert property (rd_done |-> chan_enable_i[s_r.cur]
      && (|($past(want) & (4'h1 << s_r.cur))))
      else $error("transfer by disabled or idle channel");
   dir_route_a: assert property (rd_done |-> (mem_addr_o == (c_dir ? c_ram : c_padr))
      && (ibuf.in_data.addr == (c_dir ? c_padr : c_ram)))
      else $error("source and destination swapped");
   post_inc_a: assert property (rd_done && (c_amode == AMODE_INC) && !c_last && chan_enable_i[s_r.cur]
      |=> s_r.off[$past(s_r.cur)] == $past(s_r.off[s_r.cur]) + $past(c_step))
      else $error("post-increment step wrong");
   fixed_addr_a: assert property (rd_done && (c_amode == AMODE_FIX) && chan_enable_i[s_r.cur]
      |=> s_r.off[$past(s_r.cur)] == $past(s_r.off[s_r.cur]))
      else $error("fixed address moved");
   pia_use_a: assert property (rd_done && (c_amode == AMODE_PIA) && !c_dir
      |-> ibuf.in_data.addr == pia_addr_i)
      else $error("peripheral supplied address ignored");
   force_clear_a: assert property (rd_done && !force_set_i[s_r.cur] |=> !s_r.force_b[$past(s_r.cur)])
      else $error("force bit survived its transfer");
   irq_after_write_a: assert property (s_flag_write |=> s_r.irq[$past(ibuf.out_data.chan)] ##1 1'b1)
      else $error("interrupt missing after flagged write");
   irq_cause_a: assert property ((|s_r.irq) |-> $past(wr_done) && $past(ibuf.out_data.irq))
      else $error("interrupt without a flagged write");
   ping_flip_a: assert property ((s_block_end and (c_pp && chan_enable_i[s_r.cur]))
      |=> s_r.ping[$past(s_r.cur)] != $past(s_r.ping[s_r.cur]))
      else $error("ping-pong did not swap buffers");
   oneshot_stop_a: assert property ((s_block_end and (c_os && !c_pp && chan_enable_i[s_r.cur]))
      |=> s_r.stopped[$past(s_r.cur)] ##1 !rd_done || (s_r.cur != $past(s_r.cur, 2)))
      else $error("one-shot channel did not stop");
endmodule : fcd_dma

// file: tb/fcd_mem_model.sv
// stand-in for the memory arbiter and data memory behind it
module fcd_mem_model
   import fcd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic stall_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [fcd_pkg::AW-1:0] mem_addr_i,
   input wire logic [fcd_pkg::DW-1:0] mem_wdata_i,
   output logic mem_gnt_o,
   output logic [fcd_pkg::DW-1:0] mem_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DW-1:0] junk_r = 16'h0000; // filler outside read cycles
   logic [AW+DW-1:0] wq[$]; // granted writes, address then data

   // grant unless the cpu side holds the memory (stall high)
   assign mem_gnt_o = mem_req_i & ~stall_i;
   // read data encodes the address; elsewhere it changes every cycle so a late sample shows
   assign mem_rdata_o = (mem_req_i & ~mem_we_i) ? (mem_addr_i[15:0] ^ 16'hC3C3) : junk_r;

   // log each completed write for the bench
   always @(posedge mclk_i) begin
      junk_r <= junk_r + 16'h3A5B;
      if (mem_req_i & mem_gnt_o & mem_we_i) begin
         wq.push_back({mem_addr_i, mem_wdata_i});
      end
   end
endmodule : fcd_mem_model

// file: tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import fcd_pkg::*;
   logic mclk, resetn, stall, req_o, we, bo, gnt, busy;
   logic [NCH-1:0] en, bsz, dir, half, fset, irq, frc, pend, ping, stp;
   logic [NCH-1:0][1:0] am, md;
   logic [NCH-1:0][SELW-1:0] sel;
   logic [NCH-1:0][AW-1:0] sa, sb;
   logic [NCH-1:0][15:0] pad;
   logic [NCH-1:0][CW-1:0] cnt;
   logic [NREQ-1:0] req;
   logic [AW-1:0] pia, addr;
   logic [DW-1:0] wd, rd;
   logic [AW+DW-1:0] w;
   int failures = 0;
   int n_checks = 0;
   int irqn[NCH] = '{0, 0, 0, 0}; // interrupt pulses seen per channel
   int b;
   int nbyte = 0; // byte-wide grants seen
   // request codes, peripheral address driven, address expected, direction per entry
   logic [7:0] ct[11] = '{8'h00, 8'h07, 8'h08, 8'h05, 8'h06, 8'h06, 8'h0B, 8'h0D, 8'h22, 8'h3C, 8'h3C};
   logic [15:0] pt[11] = '{16'h0800, 16'h0802, 16'h0804, 0, 0, 16'h090E, 0, 0, 0, 0, 0};
   logic [15:0] xt[11] = '{16'h0800, 16'h0802, 16'h0804, 16'h014C, 16'h0910, 16'h090E, 16'h0226, 16'h0300,
      16'h0440, 16'h0290, 16'h0298};
   logic [10:0] dt = 11'b10000110000;

   fcd_dma fcd_dma_inst (.mclk_i(mclk), .resetn_i(resetn), .chan_enable_i(en), .byte_size_i(bsz),
      .dir_to_periph_i(dir), .half_irq_i(half), .amode_i(am), .mode_i(md), .request_source_select_i(sel),
      .force_set_i(fset), .start_a_i(sa), .start_b_i(sb), .channel_peripheral_address_i(pad), .count_i(cnt),
      .req_lines_i(req), .pia_addr_i(pia), .mem_req_o(req_o), .mem_we_o(we), .mem_byte_o(bo),
      .mem_addr_o(addr), .mem_wdata_o(wd), .mem_gnt_i(gnt), .mem_rdata_i(rd), .block_irq_o(irq),
      .force_o(frc), .pending_o(pend), .ping_o(ping), .stopped_o(stp), .busy_o(busy));
   fcd_mem_model fcd_mem_model_inst (.mclk_i(mclk), .stall_i(stall), .mem_req_i(req_o), .mem_we_i(we),
      .mem_addr_i(addr), .mem_wdata_i(wd), .mem_gnt_o(gnt), .mem_rdata_o(rd));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // count interrupt pulses and byte-wide grants; a pulse stands one cycle only
   always @(posedge mclk) begin
      for (int k = 0; k < NCH; k++) if (irq[k] === 1'b1) irqn[k]++;
      if (req_o === 1'b1 && gnt === 1'b1 && bo === 1'b1) nbyte++;
   end

   task automatic chk(input logic [AW+DW-1:0] got, input logic [AW+DW-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle request pulse, driven off the falling edge
   task automatic pulse(input int code);
      @(negedge mclk);
      req[code] = 1'b1;
      @(negedge mclk);
      req[code] = 1'b0;
   endtask : pulse
   // next granted write, unknown if none turns up in time
   task automatic take(output logic [AW+DW-1:0] v);
      for (int k = 0; k < 200 && fcd_mem_model_inst.wq.size() == 0; k++) @(negedge mclk);
      v = fcd_mem_model_inst.wq.size() ? fcd_mem_model_inst.wq.pop_front() : 'x;
   endtask : take
   // disable first so the channel restarts from a clean state
   task automatic cfg(input int c, input logic d, input logic hf, input logic bs, input logic [1:0] a,
      input logic [1:0] m, input logic [7:0] s, input logic [15:0] p, input logic [CW-1:0] n,
      input logic [AW-1:0] x, input logic [AW-1:0] y);
      @(negedge mclk);
      en[c] = 1'b0;
      @(negedge mclk);
      dir[c] = d;
      half[c] = hf;
      bsz[c] = bs;
      am[c] = a;
      md[c] = m;
      sel[c] = s;
      pad[c] = p;
      cnt[c] = n;
      sa[c] = x;
      sb[c] = y;
      en[c] = 1'b1;
   endtask : cfg
   task automatic conclude();
      $display("Checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      conclude();
   end

   initial begin
      {resetn, stall, en, bsz, dir, half, fset, am, md, sel, sa, sb, pad, cnt, req, pia} = '0;
      repeat (5) @(negedge mclk);
      chk({req_o, busy, irq, frc, pend, ping, stp}, 0);
      repeat (5) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      // every listed code, both directions, default and given peripheral addresses
      for (int i = 0; i < 11; i++) begin
         cfg(0, dt[i], 0, 0, AMODE_INC, 2'b00, ct[i], pt[i], 0, 24'h010000 + 24'(i * 16), 0);
         pulse(ct[i]);
         take(w);
         chk(w[39:16], dt[i] ? {8'h00, xt[i]} : sa[0]);
         chk(w[15:0], dt[i] ? sa[0][15:0] ^ 16'hC3C3 : xt[i] ^ 16'hC3C3);
         repeat (2) @(negedge mclk);
         chk(irqn[0], i + 1);
      end
      // all four channels requested at once while the memory is held
      stall = 1'b1;
      for (int c = 0; c < NCH; c++) cfg(c, 0, 0, 0, AMODE_INC, 2'b00, 8'h07, 16'h0800, 0, 24'(32'h100000 * (c + 1)), 0);
      pulse(8'h07);
      repeat (3) @(negedge mclk);
      chk(pend, 4'hF);
      chk({req_o, we, bo, addr}, {3'b100, 24'h000800});
      stall = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         take(w);
         chk(w[39:16], sa[c]);
      end
      // half-block interrupt on a four-word block, post-increment
      cfg(1, 0, 1, 0, AMODE_INC, 2'b00, 8'h08, 16'h0804, 3, 24'h300000, 0);
      b = irqn[1];
      for (int e = 0; e < 4; e++) begin
         pulse(8'h08);
         take(w);
         chk(w[39:16], sa[1] + 24'(2 * e));
         repeat (2) @(negedge mclk);
         chk(irqn[1] - b, e > 0);
      end
      // one-shot ping-pong, byte elements, fixed address at the top of memory
      cfg(2, 0, 0, 1, AMODE_FIX, 2'b11, 8'h0D, 16'h0000, 1, 24'hFFFF00, 24'h200010);
      for (int e = 0; e < 4; e++) begin
         pulse(8'h0D);
         take(w);
         chk({w[39:16], w[7:0]}, {e < 2 ? sa[2] : sb[2], 8'hC3});
         chk(ping[2], e == 1 || e == 2);
      end
      repeat (3) @(negedge mclk);
      chk(stp[2], 1);
      chk(nbyte, 8);
      pulse(8'h0D);
      repeat (20) @(negedge mclk);
      chk(fcd_mem_model_inst.wq.size(), 0);
      // software force, then a force lost to a disable
      cfg(3, 1, 0, 0, AMODE_INC, 2'b00, 8'hFF, 16'h0806, 0, 24'h400000, 0);
      fset[3] = 1'b1;
      @(negedge mclk);
      fset[3] = 1'b0;
      chk(frc[3], 1);
      take(w);
      chk(w, {24'h000806, 16'hC3C3});
      repeat (2) @(negedge mclk);
      chk(frc[3], 0);
      stall = 1'b1;
      fset[3] = 1'b1;
      @(negedge mclk);
      fset[3] = 1'b0;
      en[3] = 1'b0;
      @(negedge mclk);
      chk(frc[3], 0);
      stall = 1'b0;
      repeat (20) @(negedge mclk);
      chk(fcd_mem_model_inst.wq.size(), 0);
      chk(busy, 0);
      // peripheral-supplied memory address
      pia = 24'hABCDE0;
      cfg(0, 0, 0, 0, AMODE_PIA, 2'b00, 8'h0B, 16'h0000, 0, 24'h500000, 0);
      pulse(8'h0B);
      take(w);
      chk(w, {24'hABCDE0, 16'h0226 ^ 16'hC3C3});
      conclude();
   end
endmodule : tb_top
